// file: rtl/tbd_base_upd.sv
// Next baseline and low-scan count of one sensor
`timescale 1ns/100ps
module tbd_base_upd #(
  parameter int CW = 16,
  parameter int LW = 8
) (
  // Settings
  tbd_cfg_if.dst cfg,
  // Current sensor values
  input wire logic first_i,
  input wire logic [CW-1:0] raw_i,
  input wire logic [CW-1:0] base_i,
  input wire logic [LW-1:0] low_i,
  // Results
  output logic [CW-1:0] base_o,
  output logic [LW-1:0] low_o,
  output logic reset_o
);
  logic signed [CW+1:0] diff;
  logic signed [CW+1:0] step;
  logic [LW:0] low_inc;
  logic is_low;
  logic is_high;

  assign diff = $signed({2'b00, raw_i}) - $signed({2'b00, base_i});
  assign step = diff >>> cfg.shift;
  assign low_inc = {1'b0, low_i} + {{LW{1'b0}}, 1'b1};
  assign is_low = diff < -$signed({2'b00, cfg.neg_noise});
  assign is_high = diff > $signed({2'b00, cfg.noise});

  always_comb begin
    base_o = base_i;
    low_o = '0;
    reset_o = 1'b0;
    if (first_i) begin
      base_o = raw_i;
    end else if (is_low) begin
      if (low_inc >= {1'b0, cfg.lbr}) begin
        base_o = raw_i;
        reset_o = 1'b1;
      end else begin
        low_o = low_inc[LW-1:0];
      end
    end else if (!is_high || cfg.auto_rst) begin
      // First-order step toward the raw count
      base_o = CW'($signed({2'b00, base_i}) + step);
    end
  end
endmodule : tbd_base_upd

// file: rtl/tbd_cfg_if.sv
// Tuning settings shared by the top and its two decision units
`timescale 1ns/100ps
interface tbd_cfg_if #(
  parameter int CW = 16,
  parameter int DW = 8,
  parameter int LW = 8,
  parameter int SW = 4
);
  logic auto_rst;
  logic [CW-1:0] noise;
  logic [CW-1:0] neg_noise;
  logic [CW-1:0] finger;
  logic [CW-1:0] hyst;
  logic [DW-1:0] deb;
  logic [LW-1:0] lbr;
  logic [SW-1:0] shift;

  modport src (output auto_rst, noise, neg_noise, finger, hyst, deb, lbr,
                shift);
  modport dst (input auto_rst, noise, neg_noise, finger, hyst, deb, lbr,
               shift);
endinterface : tbd_cfg_if

// file: rtl/tbd_pkg.sv
// Shared constants of the touch baseline and state detector
package tbd_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CNT_W = 16;
  localparam int DEB_W = 8;
  localparam int LBR_W = 8;
  localparam int SHF_W = 4;
  localparam int DLY_W = 2;
  localparam int NSH_W = 3;
  localparam int EV_W = 3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_NOISE = 8'h08;
  localparam logic [7:0] OFF_DEB = 8'h0C;
  localparam logic [7:0] OFF_INACT = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_SENS = 8'h18;
  localparam logic [7:0] OFF_INT_STAT = 8'h1C;
  localparam logic [7:0] OFF_INT_EN = 8'h20;
  localparam logic [7:0] OFF_INT_CLR = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_SHEN = 1;
  localparam int CTRL_INACT = 2;
  localparam int CTRL_DLY_LSB = 4;
  localparam int CTRL_NSH_LSB = 8;
  localparam int CTRL_SHF_LSB = 12;
  localparam int CTRL_SEL_LSB = 16;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int DEB_LSB = 0;
  localparam int LBR_LSB = 8;
  localparam int EV_ON = 0;
  localparam int EV_OFF = 1;
  localparam int EV_LBR = 2;

  // ****************************************
  // Reset values
  // ****************************************
  // Shift 2, one shield electrode, everything else off
  localparam logic [31:0] CTRL_RST = 32'h0000_2100;
  // Finger 80, hysteresis 10 (signal of 100 counts)
  localparam logic [31:0] THR_RST = 32'h000A_0050;
  // Noise 40, negative noise 40
  localparam logic [31:0] NOISE_RST = 32'h0028_0028;
  // Debounce 3, low baseline reset 30
  localparam logic [31:0] DEB_RST = 32'h0000_1E03;

endpackage : tbd_pkg

// file: rtl/tbd_top.sv
// Touch baseline tracking, state detection and shield control
// Contract
// - A raw count inside the noise band pulls the baseline toward it.
// - A raw count above baseline plus noise threshold leaves it unchanged.
// - A raw count below the negative band holds the baseline and is counted.
// - After the set number of low scans the baseline loads the raw count.
// - The signal is raw count minus baseline and drives the touch state.
// - A signal at or above finger plus hysteresis makes the ON condition.
// - A signal at or below finger minus hysteresis reports OFF.
// - Settings reset to debounce 3, low reset 30, noise bands at 40 pct.
// - Idle sensors go to shield or ground, globally or per sensor.
// - The shield drive takes a selectable delay to match the sensor.
// - One or several shield electrodes all carry the shield waveform.
// - ON is reported only after the debounce count of ON scans in a row.
// - With auto reset the baseline follows every scan above the low band.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module tbd_top #(
  parameter int NUM_SENS = 4,
  parameter int CNT_W = tbd_pkg::CNT_W,
  parameter int NUM_SHIELD = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Scan results
  input wire logic raw_valid_i,
  input wire logic [$clog2(NUM_SENS)-1:0] raw_sensor_i,
  input wire logic [CNT_W-1:0] raw_count_i,
  // Shield and idle sensors
  input wire logic sense_drive_i,
  output logic shield_en_o,
  output logic [NUM_SHIELD-1:0] shield_o,
  output logic [NUM_SENS-1:0] inactive_shield_o,
  // Touch state and interrupt
  output logic [NUM_SENS-1:0] touch_o,
  output logic irq_o
);
  localparam int IW = $clog2(NUM_SENS);
  localparam int DW = tbd_pkg::DEB_W;
  localparam int LW = tbd_pkg::LBR_W;
  localparam int SW = tbd_pkg::SHF_W;
  localparam int TAPS = 1 << tbd_pkg::DLY_W;

  typedef struct packed {
    logic [NUM_SENS-1:0][CNT_W-1:0] base;
    logic [NUM_SENS-1:0][CNT_W+1:0] sig;
    logic [NUM_SENS-1:0][LW-1:0] low_cnt;
    logic [NUM_SENS-1:0][DW-1:0] deb_cnt;
    logic [NUM_SENS-1:0] init;
    logic [NUM_SENS-1:0] on;
    logic [31:0] ctrl;
    logic [31:0] thr;
    logic [31:0] noise;
    logic [31:0] deb;
    logic [31:0] inact_reg;
    logic [tbd_pkg::EV_W-1:0] ist;
    logic [tbd_pkg::EV_W-1:0] ien;
    logic ack;
    logic [31:0] rdat;
    logic [TAPS-1:0] dly;
    logic [NUM_SHIELD-1:0] shield;
    logic [NUM_SENS-1:0] inact;
  } tbd_state_s;

  tbd_state_s st;
  tbd_state_s next_st;

  // ****************************************
  // Settings and decision units
  // ****************************************
  tbd_cfg_if #(.CW(CNT_W), .DW(DW), .LW(LW), .SW(SW)) cfg ();

  assign cfg.auto_rst = st.ctrl[tbd_pkg::CTRL_AUTO];
  assign cfg.shift = st.ctrl[tbd_pkg::CTRL_SHF_LSB +: SW];
  assign cfg.finger = st.thr[tbd_pkg::LO_LSB +: CNT_W];
  assign cfg.hyst = st.thr[tbd_pkg::HI_LSB +: CNT_W];
  assign cfg.noise = st.noise[tbd_pkg::LO_LSB +: CNT_W];
  assign cfg.neg_noise = st.noise[tbd_pkg::HI_LSB +: CNT_W];
  assign cfg.deb = st.deb[tbd_pkg::DEB_LSB +: DW];
  assign cfg.lbr = st.deb[tbd_pkg::LBR_LSB +: LW];

  logic [IW-1:0] idx;
  logic idx_ok;
  logic first;
  logic [CNT_W-1:0] base_eff;
  logic signed [CNT_W+1:0] sig;
  logic [CNT_W-1:0] bu_base;
  logic [LW-1:0] bu_low;
  logic bu_rst;
  logic td_on;
  logic [DW-1:0] td_cnt;

  assign idx = raw_sensor_i;
  assign idx_ok = {1'b0, raw_sensor_i} < (IW+1)'(NUM_SENS);
  assign first = !st.init[idx];
  assign base_eff = first ? raw_count_i : st.base[idx];
  // Signal seen by the state decision
  assign sig = $signed({2'b00, raw_count_i}) - $signed({2'b00, base_eff});

  tbd_base_upd #(.CW(CNT_W), .LW(LW)) u_base (
    .cfg(cfg.dst),
    .first_i(first),
    .raw_i(raw_count_i),
    .base_i(st.base[idx]),
    .low_i(st.low_cnt[idx]),
    .base_o(bu_base),
    .low_o(bu_low),
    .reset_o(bu_rst)
  );

  tbd_touch_dec #(.CW(CNT_W), .DW(DW)) u_touch (
    .cfg(cfg.dst),
    .sig_i(sig),
    .on_i(st.on[idx]),
    .cnt_i(st.deb_cnt[idx]),
    .on_o(td_on),
    .cnt_o(td_cnt)
  );

  // ****************************************
  // Shield drive and idle sensor routing
  // ****************************************
  logic tap;
  logic [tbd_pkg::NSH_W-1:0] nsh;
  logic [NUM_SHIELD-1:0] shield_w;
  logic [NUM_SENS-1:0] inact_w;

  // Delay of the shield against the sense drive
  assign tap = st.dly[st.ctrl[tbd_pkg::CTRL_DLY_LSB +: tbd_pkg::DLY_W]];
  assign nsh = st.ctrl[tbd_pkg::CTRL_NSH_LSB +: tbd_pkg::NSH_W];

  for (genvar i = 0; i < NUM_SHIELD; i++) begin : g_shield
    assign shield_w[i] = st.ctrl[tbd_pkg::CTRL_SHEN] & tap &
                         (i < int'(nsh));
  end

  for (genvar i = 0; i < NUM_SENS; i++) begin : g_inact
    assign inact_w[i] = st.inact_reg[i] ? st.inact_reg[16 + i] :
                        st.ctrl[tbd_pkg::CTRL_INACT];
  end

  // ****************************************
  // Register access
  // ****************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  logic req;
  logic [7:0] adr;
  logic [IW-1:0] rsel;

  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign rsel = st.ctrl[tbd_pkg::CTRL_SEL_LSB +: IW];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [tbd_pkg::EV_W-1:0] ev;
    logic [tbd_pkg::EV_W-1:0] clr;
    ev = '0;
    clr = '0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.dly = {st.dly[TAPS-2:0], sense_drive_i};
    next_st.shield = shield_w;
    next_st.inact = inact_w;
    if (raw_valid_i && idx_ok) begin
      next_st.init[idx] = 1'b1;
      next_st.base[idx] = bu_base;
      next_st.low_cnt[idx] = bu_low;
      next_st.deb_cnt[idx] = td_cnt;
      next_st.on[idx] = td_on;
      next_st.sig[idx] = sig;
      ev[tbd_pkg::EV_ON] = td_on & ~st.on[idx];
      ev[tbd_pkg::EV_OFF] = ~td_on & st.on[idx];
      ev[tbd_pkg::EV_LBR] = bu_rst;
    end
    if (req) begin
      next_st.ack = 1'b1;
      case (adr)
        tbd_pkg::OFF_CTRL: next_st.rdat = st.ctrl;
        tbd_pkg::OFF_THR: next_st.rdat = st.thr;
        tbd_pkg::OFF_NOISE: next_st.rdat = st.noise;
        tbd_pkg::OFF_DEB: next_st.rdat = st.deb;
        tbd_pkg::OFF_INACT: next_st.rdat = st.inact_reg;
        tbd_pkg::OFF_STATE: next_st.rdat = 32'(st.on);
        tbd_pkg::OFF_SENS: begin
          next_st.rdat = {st.sig[rsel][15:0], st.base[rsel][15:0]};
        end
        tbd_pkg::OFF_INT_STAT: next_st.rdat = 32'(st.ist);
        tbd_pkg::OFF_INT_EN: next_st.rdat = 32'(st.ien);
        default: next_st.rdat = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        case (adr)
          tbd_pkg::OFF_CTRL: begin
            next_st.ctrl = be_merge(st.ctrl, wb_dat_i, wb_sel_i);
          end
          tbd_pkg::OFF_THR: begin
            next_st.thr = be_merge(st.thr, wb_dat_i, wb_sel_i);
          end
          tbd_pkg::OFF_NOISE: begin
            next_st.noise = be_merge(st.noise, wb_dat_i, wb_sel_i);
          end
          tbd_pkg::OFF_DEB: begin
            next_st.deb = be_merge(st.deb, wb_dat_i, wb_sel_i);
          end
          tbd_pkg::OFF_INACT: begin
            next_st.inact_reg = be_merge(st.inact_reg, wb_dat_i, wb_sel_i);
          end
          tbd_pkg::OFF_INT_EN: begin
            if (wb_sel_i[0]) begin
              next_st.ien = wb_dat_i[tbd_pkg::EV_W-1:0];
            end
          end
          tbd_pkg::OFF_INT_CLR: begin
            clr = wb_dat_i[tbd_pkg::EV_W-1:0] & {tbd_pkg::EV_W{wb_sel_i[0]}};
          end
          default: begin
          end
        endcase
      end
    end
    // A new event wins over a clear in the same cycle
    next_st.ist = (st.ist & ~clr) | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl <= tbd_pkg::CTRL_RST;
      st.thr <= tbd_pkg::THR_RST;
      st.noise <= tbd_pkg::NOISE_RST;
      st.deb <= tbd_pkg::DEB_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign touch_o = st.on;
  assign shield_o = st.shield;
  assign shield_en_o = st.ctrl[tbd_pkg::CTRL_SHEN];
  assign inactive_shield_o = st.inact;
  assign irq_o = |(st.ist & st.ien);

  // ****************************************
  // Assertions
  // ****************************************
  logic scan_ok;
  logic low_c;
  logic high_c;
  logic on_c;
  logic off_c;
  logic lbr_hit;
  logic deb_hit;
  logic [CNT_W-1:0] exp_base;
  logic h_v;
  logic [IW-1:0] h_idx;
  logic [CNT_W-1:0] h_base;
  logic [CNT_W-1:0] h_raw;
  logic [CNT_W-1:0] h_exp;
  logic [LW-1:0] h_low;
  logic h_on;

  assign scan_ok = raw_valid_i && idx_ok && !first;
  assign low_c = sig < -$signed({2'b00, cfg.neg_noise});
  assign high_c = sig > $signed({2'b00, cfg.noise});
  assign on_c = sig >= $signed({2'b00, cfg.finger}) +
                $signed({2'b00, cfg.hyst});
  assign off_c = sig <= $signed({2'b00, cfg.finger}) -
                 $signed({2'b00, cfg.hyst});
  assign lbr_hit = ({1'b0, st.low_cnt[idx]} + 9'h001) >= {1'b0, cfg.lbr};
  assign deb_hit = ({1'b0, st.deb_cnt[idx]} + 9'h001) >= {1'b0, cfg.deb};
  assign exp_base = CNT_W'($signed({2'b00, base_eff}) + (sig >>> cfg.shift));

  always_ff @(posedge clk_i) begin
    h_v <= raw_valid_i && idx_ok;
    h_idx <= idx;
    h_base <= base_eff;
    h_raw <= raw_count_i;
    h_exp <= exp_base;
    h_low <= st.low_cnt[idx];
    h_on <= st.on[idx];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_low_scan;
    scan_ok && low_c;
  endsequence

  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_track;
    scan_ok && !low_c && !high_c |=> st.base[h_idx] == h_exp;
  endproperty
  a_track: assert property (p_track)
    else $error("baseline did not filter inside the band");

  property p_hold_high;
    scan_ok && high_c && !cfg.auto_rst |=> st.base[h_idx] == h_base;
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("baseline moved on a high raw count");

  property p_low_hold;
    s_low_scan and !lbr_hit
      |=> st.base[h_idx] == h_base && st.low_cnt[h_idx] == h_low + 8'h01;
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("low scan not held and counted");

  property p_low_reset;
    s_low_scan and lbr_hit
      |=> st.base[h_idx] == h_raw && st.low_cnt[h_idx] == '0 &&
          st.ist[tbd_pkg::EV_LBR];
  endproperty
  a_low_reset: assert property (p_low_reset)
    else $error("low baseline reset missed");

  property p_signal;
    raw_valid_i && idx_ok |=> st.sig[h_idx] ==
      (CNT_W+2)'($signed({2'b00, h_raw}) - $signed({2'b00, h_base}));
  endproperty
  a_signal: assert property (p_signal)
    else $error("stored signal is not raw minus baseline");

  property p_on;
    raw_valid_i && idx_ok && on_c && deb_hit |=> st.on[h_idx];
  endproperty
  a_on: assert property (p_on)
    else $error("sensor not ON after debounce");

  property p_off;
    raw_valid_i && idx_ok && off_c |=> !st.on[h_idx];
  endproperty
  a_off: assert property (p_off)
    else $error("sensor not OFF below lower limit");

  property p_debounce;
    raw_valid_i && idx_ok && on_c && !deb_hit && !st.on[idx]
      |=> !st.on[h_idx] ##1 (h_v || st.on == $past(st.on));
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("sensor ON before debounce count");

  property p_auto;
    scan_ok && cfg.auto_rst && !low_c |=> st.base[h_idx] == h_exp;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto reset did not update baseline");

  property p_keep;
    raw_valid_i && idx_ok && !on_c && !off_c |=> st.on[h_idx] == h_on;
  endproperty
  a_keep: assert property (p_keep)
    else $error("state changed between the limits");

  property p_shield;
    st.ctrl[tbd_pkg::CTRL_SHEN] && nsh != '0 &&
    st.ctrl[tbd_pkg::CTRL_DLY_LSB +: tbd_pkg::DLY_W] == '0 &&
    $stable(st.ctrl) |=> shield_o[0] == $past(sense_drive_i, 2);
  endproperty
  a_shield: assert property (p_shield)
    else $error("shield does not follow the sense drive");

  property p_bus;
    req |=> s_bus_answer;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not a single cycle ack");

endmodule : tbd_top

// file: rtl/tbd_touch_dec.sv
// ON/OFF decision with hysteresis and debounce for one sensor
`timescale 1ns/100ps
module tbd_touch_dec #(
  parameter int CW = 16,
  parameter int DW = 8
) (
  // Settings
  tbd_cfg_if.dst cfg,
  // Current sensor values
  input wire logic signed [CW+1:0] sig_i,
  input wire logic on_i,
  input wire logic [DW-1:0] cnt_i,
  // Results
  output logic on_o,
  output logic [DW-1:0] cnt_o
);
  logic signed [CW+1:0] on_lim;
  logic signed [CW+1:0] off_lim;
  logic [DW:0] cnt_inc;

  assign on_lim = $signed({2'b00, cfg.finger}) + $signed({2'b00, cfg.hyst});
  assign off_lim = $signed({2'b00, cfg.finger}) - $signed({2'b00, cfg.hyst});
  assign cnt_inc = {1'b0, cnt_i} + {{DW{1'b0}}, 1'b1};

  always_comb begin
    on_o = on_i;
    cnt_o = '0;
    if (sig_i >= on_lim) begin
      cnt_o = cnt_inc[DW] ? cnt_i : cnt_inc[DW-1:0];
      if (cnt_inc >= {1'b0, cfg.deb}) begin
        on_o = 1'b1;
      end
    end else if (sig_i <= off_lim) begin
      on_o = 1'b0;
    end
  end
endmodule : tbd_touch_dec

// file: test/tb_touch_baseline_and_state_detector.sv
// Self-checking bench of the touch baseline and state detector
`timescale 1ns/100ps
module tb_touch_baseline_and_state_detector;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, go = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [1:0] sen = 2'h0;
  logic [15:0] cnt = 16'h0000;
  logic rv, sd, ack, sh_en, irq;
  logic [1:0] rs;
  logic [15:0] rc, eb;
  logic [31:0] rdat, q;
  logic [3:0] sh, inact, touch;
  logic [7:0] h = 8'h00;
  int n_errors = 0;
  int samples_checked = 0;
  integer seed = 32'hd619820e;
  int d;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) h <= {h[6:0], sd};

  tbd_scan_model tbd_scan_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .go_i(go), .sen_i(sen), .cnt_i(cnt), .raw_valid_o(rv),
    .raw_sensor_o(rs), .raw_count_o(rc), .sense_drive_o(sd));

  tbd_top tbd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .raw_valid_i(rv),
    .raw_sensor_i(rs), .raw_count_i(rc), .sense_drive_i(sd),
    .shield_en_o(sh_en), .shield_o(sh), .inactive_shield_o(inact),
    .touch_o(touch), .irq_o(irq));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] f_base(logic [15:0] b, int v, bit a);
    if (v > 40 && !a) begin
      return b;
    end
    return b + 16'(v >>> 2);
  endfunction : f_base

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %0t %s", $time, m);
      n_errors++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] v);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= v;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'h1) begin
      i++;
      if (i > 20) begin
        chk(32'h0000_0000, 32'h0000_0001, "bus timeout");
        final_report();
      end
      @(posedge clk_i);
    end
    // Data taken at the edge that samples ack, then release
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    wb(1'h0, a, 32'h0000_0000);
    chk(q, e, m);
  endtask : rd

  task automatic scan(input logic [1:0] s, input logic [15:0] c);
    @(posedge clk_i);
    go <= 1'h1;
    sen <= s;
    cnt <= c;
    @(posedge clk_i);
    go <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask : scan

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(tbd_pkg::OFF_CTRL, tbd_pkg::CTRL_RST, "ctrl reset");
    rd(tbd_pkg::OFF_NOISE, 32'h0028_0028, "noise reset");
    rd(tbd_pkg::OFF_DEB, 32'h0000_1E03, "debounce reset");
    wb(1'h1, 8'hF0, 32'hFFFF_FFFF);
    rd(8'hF0, 32'h0000_0000, "unmapped");
    $display("test reset done");
    scan(2'h0, 16'h03E8);
    rd(tbd_pkg::OFF_SENS, 32'h0000_03E8, "seed");
    for (int k = 0; k < 3; k++) begin
      scan(2'h0, 16'h0442);
      chk(32'(touch[0]), 32'(k == 2), "debounce");
    end
    rd(tbd_pkg::OFF_STATE, 32'h0000_0001, "state readback");
    rd(tbd_pkg::OFF_SENS, 32'h005A_03E8, "held high");
    scan(2'h0, 16'h0433);
    chk(32'(touch[0]), 32'h0000_0001, "between");
    scan(2'h0, 16'h042E);
    chk(32'(touch[0]), 32'h0000_0000, "off");
    rd(tbd_pkg::OFF_INT_STAT, 32'h0000_0003, "events");
    scan(2'h0, 16'h03FC);
    rd(tbd_pkg::OFF_SENS, 32'h0014_03ED, "filter");
    $display("test touch done");
    wb(1'h1, tbd_pkg::OFF_CTRL, 32'h0001_2100);
    scan(2'h1, 16'h07D0);
    eb = 16'h07D0;
    for (int k = 0; k < 10; k++) begin
      d = (k == 0) ? 40 : (k == 1) ? -40 : (k == 2) ? 41 : $random(seed) % 41;
      scan(2'h1, eb + 16'(d));
      eb = f_base(eb, d, 1'b0);
      rd(tbd_pkg::OFF_SENS, {16'(d), eb}, "random band");
    end
    $display("test random done");
    wb(1'h1, tbd_pkg::OFF_CTRL, 32'h0000_2100);
    wb(1'h1, tbd_pkg::OFF_INT_CLR, 32'h0000_0007);
    wb(1'h1, tbd_pkg::OFF_INT_EN, 32'h0000_0004);
    for (int k = 0; k < 29; k++) begin
      scan(2'h0, 16'h0384);
    end
    rd(tbd_pkg::OFF_SENS, 32'hFF97_03ED, "low held");
    chk(32'(irq), 32'h0000_0000, "no early reset");
    scan(2'h0, 16'h0384);
    wb(1'h0, tbd_pkg::OFF_SENS, 32'h0000_0000);
    chk(q & 32'h0000_FFFF, 32'h0000_0384, "low reset");
    chk(32'(irq), 32'h0000_0001, "irq");
    wb(1'h1, tbd_pkg::OFF_INT_EN, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000, "masked");
    wb(1'h1, tbd_pkg::OFF_INT_EN, 32'h0000_0004);
    wb(1'h1, tbd_pkg::OFF_INT_CLR, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000, "cleared");
    $display("test low done");
    wb(1'h1, tbd_pkg::OFF_CTRL, 32'h0000_2101);
    scan(2'h0, 16'h03E8);
    rd(tbd_pkg::OFF_SENS, 32'h0064_039D, "auto");
    wb(1'h1, tbd_pkg::OFF_CTRL, 32'h0000_2226);
    chk(32'(sh_en), 32'h0000_0001, "shield en");
    // Idle routing is registered one cycle after the setting
    @(posedge clk_i);
    chk(32'(inact), 32'h0000_000F, "idle shield");
    wb(1'h1, tbd_pkg::OFF_INACT, 32'h0000_0002);
    @(posedge clk_i);
    chk(32'(inact), 32'h0000_000D, "idle override");
    repeat (20) begin
      @(negedge clk_i);
      chk(32'(sh), 32'({2'h0, {2{h[3]}}}), "shield");
    end
    // Zero added delay: two cycles of pipeline only
    wb(1'h1, tbd_pkg::OFF_CTRL, 32'h0000_2206);
    repeat (20) begin
      @(negedge clk_i);
      chk(32'(sh), 32'({2'h0, {2{h[1]}}}), "shield no delay");
    end
    $display("test shield done");
    final_report();
  end
endmodule : tb_touch_baseline_and_state_detector

// file: test/tbd_scan_model.sv
// Scan converter stand-in that delivers raw counts and a drive waveform
`timescale 1ns/100ps
module tbd_scan_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic go_i,
  input wire logic [1:0] sen_i,
  input wire logic [15:0] cnt_i,
  // Scan results and drive
  output logic raw_valid_o,
  output logic [1:0] raw_sensor_o,
  output logic [15:0] raw_count_o,
  output logic sense_drive_o
);
  // ****************************************
  // Result pulse, lines scrambled when idle
  // ****************************************
  logic [1:0] ph;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_valid_o <= 1'h0;
      raw_sensor_o <= 2'h0;
      raw_count_o <= 16'h0000;
      sense_drive_o <= 1'h0;
      ph <= 2'h0;
    end else begin
      raw_valid_o <= go_i;
      raw_sensor_o <= go_i ? sen_i : raw_sensor_o + 2'h1;
      raw_count_o <= go_i ? cnt_i : ~raw_count_o;
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        sense_drive_o <= ~sense_drive_o;
      end
    end
  end
endmodule : tbd_scan_model
